// [shared/expander_pkg.sv]
// Constants and types shared by the I2C port expander front end
package expander_pkg;

  // Slave address: fixed upper nibble, select bits below it
  localparam logic [3:0] ADDR_FIXED = 4'h4;

  // Register pointer codes
  localparam logic [1:0] PTR_INPUT = 2'h0;
  localparam logic [1:0] PTR_OUTPUT = 2'h1;
  localparam logic [1:0] PTR_POLARITY = 2'h2;
  localparam logic [1:0] PTR_CONFIG = 2'h3;

  // Register reset values
  localparam logic [7:0] OUT_RST = 8'hff;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'hff;
  localparam logic [7:0] LATCH_RST = 8'hff;

  // Bits in one byte on the bus
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Noise filter: a level must hold this long before it is believed
  localparam int FILT_NS = 100;
  localparam int LINK_PERIOD_NS = 30;
  localparam int FILT_CYCLES = (FILT_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam logic [2:0] FILT_LAST = 3'(FILT_CYCLES - 1);

  // Bus side sequencer states
  typedef enum logic [2:0] {
    L_IDLE = 3'h0,
    L_ADDR = 3'h1,
    L_ACK = 3'h2,
    L_WDATA = 3'h3,
    L_RDATA = 3'h4,
    L_RACK = 3'h5,
    L_WAIT = 3'h6
  } link_state_t;

  // One filtered bus line
  typedef struct packed {
    logic f;
    logic [2:0] cnt;
  } filt_t;

  // Register image handed from the bus domain to the port domain
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] cfg;
    logic [7:0] latch;
  } snap_t;

  // All state of the bus domain
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [2:0] sel_m;
    logic [2:0] sel_s;
    logic [7:0] pin_m;
    logic [7:0] pin_s;
    filt_t scl;
    filt_t sda;
    logic scl_p;
    logic sda_p;
    link_state_t state;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic ptr_phase;
    logic [1:0] ptr;
    logic [7:0] out;
    logic [7:0] pol;
    logic [7:0] cfg;
    logic [7:0] latch;
    logic sda_oe;
    logic sda_o;
    snap_t snap;
    logic req;
    logic ack_m;
    logic ack_s;
  } link_st_t;

  // All state of the port domain
  typedef struct packed {
    logic [7:0] pin_m;
    logic [7:0] pin_s;
    logic req_m;
    logic req_s;
    logic ack;
    snap_t snap;
    logic [7:0] port_out;
    logic [7:0] port_oe;
    logic int_oe;
    logic int_o;
  } core_st_t;

endpackage

// [hw/port_expander.sv]
// I2C slave port expander: bus sequencer on the link clock, pins and interrupt on CLK
//
// Behaviour
// - Select pins must equal address bits two, one, zero to match.
// - Input pins are high impedance; output pins get a push-pull driver.
// - Interrupt pulls low when an input pin differs from the stored input bit.
// - Interrupt releases when the pin returns or the input register is read.
// - Output-to-input switch may raise interrupt if pin disagrees with stored bit.
// - Master makes clock, START and STOP; device acts only as slave.
// - SDA stable while SCL high; any change then is START or STOP.
// - START is SDA falling with SCL high; nothing happens before it.
// - Address upper four bits must be the fixed pattern.
// - Eighth bit is direction: one reads, zero writes.
// - Acknowledge address only on match, then read or write per direction.
// - Receiver acknowledges by holding SDA low through the ninth clock.
// - In write mode every received byte is acknowledged.
// - Read mode shifts eight bits, releases SDA, continues on acknowledge.
// - Without acknowledge the device stops sending and waits for STOP.
// - SDA is only pulled low or released, never driven high.
// - First written byte is the pointer; codes zero to three pick registers.
// - Polarity bit set inverts the input register bit.
// - Configuration bit one makes an input, zero an output.
// - Pointer persists for later reads until a new pointer is written.
module port_expander (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic LINK_CLK,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic DEV_SELECT_BIT0,
  input wire logic DEV_SELECT_BIT1,
  input wire logic DEV_SELECT_BIT2,
  input wire logic [7:0] PORT_PINS_I,
  output logic [7:0] PORT_PINS_O,
  output logic [7:0] PORT_PINS_OE,
  output logic INT_N_O,
  output logic INT_N_OE
);

  expander_pkg::link_st_t l_r;
  expander_pkg::link_st_t l_nxt;
  expander_pkg::core_st_t c_r;
  expander_pkg::core_st_t c_nxt;
  expander_pkg::snap_t snap_cur;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // Filter step: take a new level only after it has held FILT_CYCLES samples
  function automatic expander_pkg::filt_t filt_step(input expander_pkg::filt_t cur, input logic s);
    expander_pkg::filt_t nx;
    nx = cur;
    if (s == cur.f) begin
      nx.cnt = 3'h0;
    end else if (cur.cnt == expander_pkg::FILT_LAST) begin
      nx.f = s;
      nx.cnt = 3'h0;
    end else begin
      nx.cnt = cur.cnt + 3'h1;
    end
    return nx;
  endfunction

  // Address byte matches fixed nibble and the select pins
  function automatic logic addr_match(input logic [7:0] b, input logic [2:0] sel);
    return (b[7:4] == expander_pkg::ADDR_FIXED) && (b[3:1] == sel);
  endfunction

  // Value returned for a register pointer
  function automatic logic [7:0] rd_byte(input expander_pkg::link_st_t s);
    logic [7:0] v;
    v = 8'h00;
    case (s.ptr)
      // Polarity bit flips the input value
      expander_pkg::PTR_INPUT: v = s.pin_s ^ s.pol;
      expander_pkg::PTR_OUTPUT: v = s.out;
      expander_pkg::PTR_POLARITY: v = s.pol;
      expander_pkg::PTR_CONFIG: v = s.cfg;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Bus events from the filtered lines only
  assign scl_rise = l_r.scl.f & ~l_r.scl_p;
  assign scl_fall = ~l_r.scl.f & l_r.scl_p;
  assign bus_start = l_r.scl.f & l_r.scl_p & l_r.sda_p & ~l_r.sda.f;
  assign bus_stop = l_r.scl.f & l_r.scl_p & ~l_r.sda_p & l_r.sda.f;
  assign snap_cur = '{out: l_r.out, cfg: l_r.cfg, latch: l_r.latch};

  // Bus domain next state
  always_comb begin
    logic load;
    load = 1'b0;
    l_nxt = l_r;
    // Slave only: SCL is sampled here and never driven
    l_nxt.scl_sync = {l_r.scl_sync[0], SCL};
    l_nxt.sda_sync = {l_r.sda_sync[0], SDA_I};
    l_nxt.sel_m = {DEV_SELECT_BIT2, DEV_SELECT_BIT1, DEV_SELECT_BIT0};
    l_nxt.sel_s = l_r.sel_m;
    l_nxt.pin_m = PORT_PINS_I;
    l_nxt.pin_s = l_r.pin_m;
    l_nxt.scl = filt_step(l_r.scl, l_r.scl_sync[1]);
    l_nxt.sda = filt_step(l_r.sda, l_r.sda_sync[1]);
    l_nxt.scl_p = l_r.scl.f;
    l_nxt.sda_p = l_r.sda.f;
    // Open drain: the data level is always low, only the enable moves
    l_nxt.sda_o = 1'b0;
    if (bus_start) begin
      // Any START, even repeated, restarts address reception
      l_nxt.state = expander_pkg::L_ADDR;
      l_nxt.cnt = 4'h0;
      l_nxt.sda_oe = 1'b0;
    end else if (bus_stop) begin
      l_nxt.state = expander_pkg::L_IDLE;
      l_nxt.sda_oe = 1'b0;
    end else begin
      case (l_r.state)
        expander_pkg::L_ADDR, expander_pkg::L_WDATA: begin
          if (scl_rise) begin
            l_nxt.sh = {l_r.sh[6:0], l_r.sda.f};
            l_nxt.cnt = l_r.cnt + 4'h1;
          end else if (scl_fall && l_r.cnt == expander_pkg::BITS_PER_BYTE) begin
            l_nxt.cnt = 4'h0;
            if (l_r.state == expander_pkg::L_ADDR) begin
              if (addr_match(l_r.sh, l_r.sel_s)) begin
                l_nxt.sda_oe = 1'b1;
                l_nxt.rw = l_r.sh[0];
                l_nxt.ptr_phase = ~l_r.sh[0];
                l_nxt.state = expander_pkg::L_ACK;
              end else begin
                l_nxt.state = expander_pkg::L_WAIT;
              end
            end else begin
              l_nxt.sda_oe = 1'b1;
              l_nxt.state = expander_pkg::L_ACK;
              if (l_r.ptr_phase) begin
                l_nxt.ptr = l_r.sh[1:0];
                l_nxt.ptr_phase = 1'b0;
              end else begin
                case (l_r.ptr)
                  expander_pkg::PTR_OUTPUT: l_nxt.out = l_r.sh;
                  expander_pkg::PTR_POLARITY: l_nxt.pol = l_r.sh;
                  expander_pkg::PTR_CONFIG: l_nxt.cfg = l_r.sh;
                  // Input register is read only, writes fall away
                  default: l_nxt.out = l_r.out;
                endcase
              end
            end
          end
        end
        expander_pkg::L_ACK: begin
          // Hold the acknowledge low until SCL falls again
          if (scl_fall) begin
            l_nxt.sda_oe = 1'b0;
            l_nxt.state = expander_pkg::L_WDATA;
            load = l_r.rw;
          end
        end
        expander_pkg::L_RDATA: begin
          if (scl_rise) begin
            l_nxt.cnt = l_r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (l_r.cnt == expander_pkg::BITS_PER_BYTE) begin
              // Free the line for the master's acknowledge
              l_nxt.sda_oe = 1'b0;
              l_nxt.state = expander_pkg::L_RACK;
            end else begin
              l_nxt.sh = {l_r.sh[6:0], 1'b1};
              l_nxt.sda_oe = ~l_r.sh[6];
            end
          end
        end
        expander_pkg::L_RACK: begin
          // No acknowledge: stop sending and wait
          if (scl_rise && l_r.sda.f) begin
            l_nxt.state = expander_pkg::L_WAIT;
          end else if (scl_fall) begin
            load = 1'b1;
          end
        end
        // Idle and wait ignore everything but START and STOP
        expander_pkg::L_IDLE, expander_pkg::L_WAIT: l_nxt.state = l_r.state;
        default: l_nxt.state = expander_pkg::L_IDLE;
      endcase
    end
    if (load) begin
      // Reads keep using the last pointer
      l_nxt.sh = rd_byte(l_r);
      // A one is sent by releasing the line
      l_nxt.sda_oe = ~l_nxt.sh[7];
      l_nxt.cnt = 4'h0;
      l_nxt.state = expander_pkg::L_RDATA;
      // Reading the input register refreshes the compare image
      if (l_r.ptr == expander_pkg::PTR_INPUT) begin
        l_nxt.latch = l_r.pin_s;
      end
    end
    // Handshake out the register image; a new one only after the last was taken
    l_nxt.ack_m = c_r.ack;
    l_nxt.ack_s = l_r.ack_m;
    if (l_r.ack_s == l_r.req && l_r.snap != snap_cur) begin
      l_nxt.snap = snap_cur;
      l_nxt.req = ~l_r.req;
    end
  end

  // Bus domain registers
  always_ff @(posedge LINK_CLK or negedge RESETN) begin
    if (!RESETN) begin
      l_r <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl: '{f: 1'b1, cnt: 3'h0}, sda: '{f: 1'b1, cnt: 3'h0},
               scl_p: 1'b1, sda_p: 1'b1, state: expander_pkg::L_IDLE, out: expander_pkg::OUT_RST,
               pol: expander_pkg::POL_RST, cfg: expander_pkg::CFG_RST, latch: expander_pkg::LATCH_RST,
               snap: '{out: expander_pkg::OUT_RST, cfg: expander_pkg::CFG_RST, latch: expander_pkg::LATCH_RST},
               default: '0};
    end else begin
      l_r <= l_nxt;
    end
  end

  // Port domain next state
  always_comb begin
    c_nxt = c_r;
    c_nxt.pin_m = PORT_PINS_I;
    c_nxt.pin_s = c_r.pin_m;
    c_nxt.req_m = l_r.req;
    c_nxt.req_s = c_r.req_m;
    // Image is stable while the request toggle is unanswered
    if (c_r.req_s != c_r.ack) begin
      c_nxt.snap = l_r.snap;
      c_nxt.ack = c_r.req_s;
    end
    c_nxt.port_out = c_r.snap.out;
    c_nxt.port_oe = ~c_r.snap.cfg;
    // Input pins against the stored image, output pins masked
    c_nxt.int_oe = |(c_r.snap.cfg & (c_r.pin_s ^ c_r.snap.latch));
    c_nxt.int_o = 1'b0;
  end

  // Port domain registers
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      c_r <= '{snap: '{out: expander_pkg::OUT_RST, cfg: expander_pkg::CFG_RST, latch: expander_pkg::LATCH_RST},
               port_out: expander_pkg::OUT_RST, default: '0};
    end else begin
      c_r <= c_nxt;
    end
  end

  assign SDA_O = l_r.sda_o;
  assign SDA_OE = l_r.sda_oe;
  assign PORT_PINS_O = c_r.port_out;
  assign PORT_PINS_OE = c_r.port_oe;
  assign INT_N_O = c_r.int_o;
  assign INT_N_OE = c_r.int_oe;

  // Address byte complete on the falling edge after its eighth bit
  sequence s_addr_done;
    l_r.state == expander_pkg::L_ADDR && scl_fall && l_r.cnt == expander_pkg::BITS_PER_BYTE;
  endsequence

  // Written byte complete
  sequence s_wbyte_done;
    l_r.state == expander_pkg::L_WDATA && scl_fall && l_r.cnt == expander_pkg::BITS_PER_BYTE;
  endsequence

  AST_ADDR_ACK: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    s_addr_done ##0 (l_r.sh[7:4] == expander_pkg::ADDR_FIXED && l_r.sh[3:1] == l_r.sel_s)
    |=> SDA_OE && l_r.state == expander_pkg::L_ACK)
    else $error("Matching address not acknowledged");

  AST_ADDR_NOMATCH: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    s_addr_done ##0 (l_r.sh[3:1] != l_r.sel_s) |=> !SDA_OE && l_r.state == expander_pkg::L_WAIT)
    else $error("Foreign select bits acknowledged");

  AST_FIXED_NIBBLE: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    s_addr_done ##0 (l_r.sh[7:4] != expander_pkg::ADDR_FIXED) |=> !SDA_OE [*2])
    else $error("Wrong fixed address bits acknowledged");

  AST_DIR_BIT: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    s_addr_done ##0 addr_match(l_r.sh, l_r.sel_s) |=> l_r.rw == $past(l_r.sh[0]))
    else $error("Direction bit not taken");

  AST_WRITE_ACK: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    s_wbyte_done |=> SDA_OE && l_r.state == expander_pkg::L_ACK)
    else $error("Written byte not acknowledged");

  // Acknowledge stands through the ninth clock until SCL falls again
  AST_ACK_HOLD: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    l_r.state == expander_pkg::L_ACK && !scl_fall && !bus_start && !bus_stop |=> SDA_OE)
    else $error("Acknowledge released early");

  AST_START: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    bus_start |=> l_r.state == expander_pkg::L_ADDR && l_r.cnt == 4'h0 && !SDA_OE)
    else $error("START not taken");

  AST_IDLE_QUIET: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    l_r.state == expander_pkg::L_IDLE && !bus_start |=> !SDA_OE && l_r.state == expander_pkg::L_IDLE)
    else $error("Activity before START");

  AST_READ_RELEASE: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    l_r.state == expander_pkg::L_RDATA && scl_fall && l_r.cnt == expander_pkg::BITS_PER_BYTE && !bus_start && !bus_stop
    |=> !SDA_OE && l_r.state == expander_pkg::L_RACK)
    else $error("SDA not released for master acknowledge");

  AST_NACK_WAIT: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    l_r.state == expander_pkg::L_RACK && scl_rise && l_r.sda.f && !bus_stop |=> !SDA_OE ##1 !SDA_OE)
    else $error("Transmission continued after no acknowledge");

  AST_OPEN_DRAIN: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    SDA_OE |-> !SDA_O)
    else $error("SDA driven high");

  AST_FILTER: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
    $changed(l_r.scl.f) |-> $past(l_r.scl_sync[1], 1) == l_r.scl.f && $past(l_r.scl_sync[1], 4) == l_r.scl.f)
    else $error("SCL glitch passed the filter");

  AST_INT_SET: assert property (@(posedge CLK) disable iff (!RESETN)
    (c_r.snap.cfg & (c_r.pin_s ^ c_r.snap.latch)) != 8'h00 |=> INT_N_OE)
    else $error("Input change did not raise interrupt");

  AST_INT_CLEAR: assert property (@(posedge CLK) disable iff (!RESETN)
    (c_r.snap.cfg & (c_r.pin_s ^ c_r.snap.latch)) == 8'h00 |=> !INT_N_OE)
    else $error("Interrupt held without mismatch");

  AST_DIRECTION: assert property (@(posedge CLK) disable iff (!RESETN)
    $changed(c_r.snap.cfg) |=> PORT_PINS_OE == ~$past(c_r.snap.cfg))
    else $error("Pin direction does not follow configuration");

endmodule // port_expander

// [sim/i2c_master_model.sv]
// I2C bus master model: drives SCL and pulls SDA low on the shared wire
module i2c_master_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 500;

  // Bus idle: clock high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic start();
    #100 sda_low = 1'b0;
    #T scl = 1'b1;
    #T sda_low = 1'b1;
    #T scl = 1'b0;
  endtask

  task automatic stop();
    #100 sda_low = 1'b1;
    #T scl = 1'b1;
    #T sda_low = 1'b0;
    #T;
  endtask

  // data moves only while SCL is low, held past the fall
  task automatic put_bit(input logic b);
    #100 sda_low = ~b;
    #T scl = 1'b1;
    #T scl = 1'b0;
  endtask

  // Released line, sampled mid high phase
  task automatic get_bit(output logic b);
    #100 sda_low = 1'b0;
    #T scl = 1'b1;
    #(T/2) b = sda;
    #(T/2) scl = 1'b0;
  endtask

  // byte out MSB first, acknowledge read back
  task automatic send(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask

  // byte in, then acknowledge or withhold it
  task automatic recv(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(~ack);
  endtask
endmodule // i2c_master_model

// [sim/port_expander_tb.sv]
// Self-checking bench for the I2C port expander
module port_expander_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] SEL = 3'h5;
  localparam logic [7:0] ADR = {expander_pkg::ADDR_FIXED, SEL, 1'b0};
  logic clk, resetn, link_clk, scl, m_low, sda_o, sda_oe, int_o, int_oe, ack;
  logic [7:0] ext, pins_o, pins_oe, pins_i, rd;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  // Open-drain data wire with pull-up
  wire sda = ~(m_low | (sda_oe & ~sda_o));
  // Pins follow the driver where enabled, the outside world elsewhere
  assign pins_i = (pins_oe & pins_o) | (~pins_oe & ext);

  port_expander port_expander_inst (.CLK(clk), .RESETN(resetn), .LINK_CLK(link_clk), .SCL(scl),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .DEV_SELECT_BIT0(SEL[0]), .DEV_SELECT_BIT1(SEL[1]),
    .DEV_SELECT_BIT2(SEL[2]), .PORT_PINS_I(pins_i), .PORT_PINS_O(pins_o), .PORT_PINS_OE(pins_oe),
    .INT_N_O(int_o), .INT_N_OE(int_oe));
  i2c_master_model master_inst (.scl(scl), .sda_low(m_low), .sda(sda));

  // Two unrelated clocks
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic set_ext(input logic [7:0] v);
    @(posedge clk);
    #2 ext = v;
  endtask

  // Bounded wait, since the interrupt crosses synchronisers
  task automatic wait_int(input logic exp);
    int n = 0;
    while (int_oe !== exp && n < 300) begin
      wait_clk(1);
      n++;
    end
    chk("interrupt", 8'(exp), 8'(int_oe));
  endtask

  // Pointer byte then n data bytes, all acknowledged
  task automatic wr(input logic [1:0] ptr, input logic [7:0] d, input int n);
    master_inst.start();
    master_inst.send(ADR, ack);
    chk("write address ack", 8'h01, 8'(ack));
    master_inst.send({6'h00, ptr}, ack);
    chk("pointer ack", 8'h01, 8'(ack));
    for (int i = 0; i < n; i++) begin
      master_inst.send(d, ack);
      chk("data ack", 8'h01, 8'(ack));
    end
    master_inst.stop();
    wait_clk(20);
  endtask

  // n bytes read, last one not acknowledged
  task automatic rdreg(input int n, input logic [7:0] exp);
    master_inst.start();
    master_inst.send(ADR | 8'h01, ack);
    chk("read address ack", 8'h01, 8'(ack));
    for (int i = 1; i <= n; i++) begin
      master_inst.recv(i < n, rd);
      chk("read byte", exp, rd);
    end
    master_inst.stop();
    wait_clk(20);
  endtask

  task automatic t_reset();
    chk("output reg", expander_pkg::OUT_RST, pins_o);
    chk("output enables", ~expander_pkg::CFG_RST, pins_oe);
    chk("interrupt", 8'h00, 8'(int_oe));
    chk("sda pull", 8'h00, 8'(sda_oe));
    chk("sda data", 8'h00, 8'(sda_o));
    chk("interrupt level", 8'h00, 8'(int_o));
  endtask

  // Every select value, then a wrong fixed prefix
  task automatic t_addr();
    for (int a = 0; a < 8; a++) begin
      master_inst.start();
      master_inst.send({expander_pkg::ADDR_FIXED, 3'(a), 1'b0}, ack);
      master_inst.stop();
      chk("address ack", 8'(a == SEL), 8'(ack));
    end
    master_inst.start();
    master_inst.send({4'h5, SEL, 1'b0}, ack);
    master_inst.stop();
    chk("prefix ack", 8'h00, 8'(ack));
  endtask

  // Config, repeated output bytes, ignored input write
  task automatic t_write();
    wr(expander_pkg::PTR_CONFIG, 8'h0f, 1);
    chk("output enables", 8'hf0, pins_oe);
    wr(expander_pkg::PTR_OUTPUT, 8'h5a, 1);
    wr(expander_pkg::PTR_OUTPUT, 8'ha5, 2);
    chk("output reg", 8'ha5, pins_o);
    wr(expander_pkg::PTR_INPUT, 8'h00, 1);
    chk("output reg", 8'ha5, pins_o);
  endtask

  // Streaming read, pointer kept, silence after a withheld ack
  task automatic t_read();
    wr(expander_pkg::PTR_OUTPUT, 8'h00, 0);
    rdreg(2, 8'ha5);
    rdreg(1, 8'ha5);
    master_inst.start();
    master_inst.send(ADR | 8'h01, ack);
    master_inst.recv(1'b0, rd);
    master_inst.recv(1'b0, rd);
    chk("after nack", 8'hff, rd);
    master_inst.stop();
    wr(expander_pkg::PTR_POLARITY, 8'h0f, 1);
    rdreg(1, 8'h0f);
  endtask

  // Input read with inversion, then interrupt set and release
  task automatic t_int();
    set_ext(8'h03);
    wait_int(1'b1);
    wr(expander_pkg::PTR_INPUT, 8'h00, 0);
    rdreg(1, 8'hac);
    wait_int(1'b0);
    set_ext(8'h02);
    wait_int(1'b1);
    set_ext(8'h03);
    wait_int(1'b0);
    set_ext(8'h02);
    wait_int(1'b1);
    rdreg(1, 8'had);
    wait_int(1'b0);
    wr(expander_pkg::PTR_OUTPUT, 8'h25, 1);
    chk("interrupt", 8'h00, 8'(int_oe));
    wr(expander_pkg::PTR_CONFIG, 8'h8f, 1);
    chk("output enables", 8'h70, pins_oe);
    wait_int(1'b1);
    chk("interrupt level", 8'h00, 8'(int_o));
  endtask

  initial begin
    resetn = 1'b0;
    ext = 8'hff;
    repeat (16) @(posedge clk);
    #2 resetn = 1'b1;
    wait_clk(20);
    t_reset();
    t_addr();
    t_write();
    t_read();
    t_int();
    give_verdict();
  end
endmodule // port_expander_tb
